// *** pkg/pwe_pkg.sv ***
// Constants, register map and carrier types for the power enable register bank.
// Assumes an APB master with 32-bit data; register byte address is four times its index.
package pwe_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 8;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam logic [ADDR_W-1:0] IDX_DRV = 8'h0A;
  localparam logic [ADDR_W-1:0] IDX_CONV = 8'h0B;
  localparam logic [ADDR_W-1:0] IDX_SYS = 8'h0C;
  localparam logic [ADDR_W-1:0] IDX_STAT = 8'h0E;
  localparam logic [ADDR_W-1:0] IDX_KEY = 8'h0F;
  localparam logic [ADDR_W-1:0] ADDR_DRV = IDX_DRV * 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CONV = IDX_CONV * 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SYS = IDX_SYS * 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STAT = IDX_STAT * 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_KEY = IDX_KEY * 8'h04;

  // ****************************************************************
  // Writable masks, key masks and values after reset
  // ****************************************************************
  localparam logic [REG_W-1:0] DRV_MASK = 16'h008F;
  localparam logic [REG_W-1:0] DRV_RST = 16'h0000;
  localparam logic [REG_W-1:0] CONV_MASK = 16'h613C;
  localparam logic [REG_W-1:0] CONV_RST = 16'h2000;
  localparam logic [REG_W-1:0] SYS_MASK = 16'h1F8F;
  localparam logic [REG_W-1:0] SYS_RST = 16'h0E00;
  localparam logic [REG_W-1:0] SYS_KEY_MASK = 16'h0E00;
  localparam logic [REG_W-1:0] NO_KEY_MASK = 16'h0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned DRV_BEEP = 7;
  localparam int unsigned DRV_O2R = 3;
  localparam int unsigned DRV_O2L = 2;
  localparam int unsigned DRV_O1R = 1;
  localparam int unsigned DRV_O1L = 0;
  localparam int unsigned CONV_CLK = 14;
  localparam int unsigned CONV_HPF = 13;
  localparam int unsigned CONV_TOCLK = 8;
  localparam int unsigned CONV_DACR = 5;
  localparam int unsigned CONV_DACL = 4;
  localparam int unsigned CONV_ADCR = 3;
  localparam int unsigned CONV_ADCL = 2;
  localparam int unsigned SYS_CORE = 12;
  localparam int unsigned SYS_TICK = 11;
  localparam int unsigned SYS_OSC = 10;
  localparam int unsigned SYS_CHG = 9;
  localparam int unsigned SYS_BKP = 8;
  localparam int unsigned SYS_AUX = 7;
  localparam int unsigned STAT_UNLOCKED = 0;
  localparam int unsigned STAT_CORE_ON = 1;
  localparam int unsigned STAT_KEY_VIOL = 2;

  // Unlock value, arbitrary
  localparam logic [REG_W-1:0] KEY_UNLOCK = 16'h5A3C;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic beep_mixer_enable;
    logic driver_two_right_enable;
    logic driver_two_left_enable;
    logic driver_one_right_enable;
    logic driver_one_left_enable;
  } pwe_drv_s;

  typedef struct packed {
    logic audio_core_clock_enable;
    logic input_highpass_enable;
    logic zero_cross_timeout_clock_enable;
    logic right_output_converter_enable;
    logic left_output_converter_enable;
    logic right_input_converter_enable;
    logic left_input_converter_enable;
  } pwe_conv_s;

  typedef struct packed {
    logic audio_core_master_enable;
    logic clock_tick_enable;
    logic crystal_osc_enable;
    logic charger_control_enable;
    logic backup_rail_pin_enable;
    logic aux_converter_enable;
    logic [3:0] comparator_enable;
  } pwe_sys_s;

endpackage : pwe_pkg

// *** logic/pwe_rst_sync.sv ***
// Two-stage reset release synchroniser.
// Assumes an asynchronous active-low reset input.
`timescale 1ns/100ps
module pwe_rst_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic rst_n_out
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= 1'b1;
      sync_ff <= meta_ff;
    end
  end

  assign rst_n_out = sync_ff;

endmodule : pwe_rst_sync

// *** logic/pwe_field_reg.sv ***
// One enable register with write mask, key-protected bits and a synchronous hold.
// Assumes write strobe, data and byte mask come from logic on the same clock.
`timescale 1ns/100ps
module pwe_field_reg #(
  parameter int unsigned W = 16,
  parameter logic [W-1:0] RST_VAL = '0,
  parameter logic [W-1:0] WR_MASK = '1,
  parameter logic [W-1:0] KEY_MASK = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hold_in,
  input wire logic wr_in,
  input wire logic [W-1:0] wr_data_in,
  input wire logic [W-1:0] wr_bmask_in,
  input wire logic unlocked_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;
  logic [W-1:0] eff_mask;

  always_comb begin
    eff_mask = WR_MASK & wr_bmask_in & (unlocked_in ? {W{1'b1}} : ~KEY_MASK);
    nxt_q = q_ff;
    if (hold_in) begin
      nxt_q = RST_VAL;
    end else if (wr_in) begin
      nxt_q = (q_ff & ~eff_mask) | (wr_data_in & eff_mask);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_ff <= RST_VAL;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q_out = q_ff;

endmodule : pwe_field_reg

// *** logic/pwe_bank.sv ***
// Power enable register bank: APB slave, three enable registers, key and status.
// Assumes APB master on clk_in and a one-cycle state-machine reset pulse on the same clock.
//
// Function
// - Master enable clear holds audio registers reset
// - Master enable set: audio registers work normally
// - High-pass filter enable, resets to one
// - Zero-cross timeout clock enable, resets zero
// - Clock tick enable, default one
// - Crystal oscillator enable, default one
// - Charger control enable, zero forces no current
// - Key guards tick, oscillator, charger; machine restores
// - Backup rail pin switch, resets zero
// - Four comparator enables, reset and machine cleared
`timescale 1ns/100ps
module pwe_bank (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [pwe_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic sm_reset_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output pwe_pkg::pwe_drv_s drv_out,
  output pwe_pkg::pwe_conv_s conv_out,
  output pwe_pkg::pwe_sys_s sys_out,
  output logic audio_core_rst_n_out
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_n;

  pwe_rst_sync u_rst_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .rst_n_out(rst_n)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic hit_drv;
  logic hit_conv;
  logic hit_sys;
  logic hit_stat;
  logic hit_key;
  logic hit_any;
  logic [pwe_pkg::REG_W-1:0] wr_data;
  logic [pwe_pkg::REG_W-1:0] wr_bmask;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  assign setup_phase = psel_in & ~penable_in;
  assign access_done = psel_in & penable_in & pready_ff;
  assign wr_done = access_done & pwrite_in & ~pslverr_ff;
  assign hit_drv = (paddr_in == pwe_pkg::ADDR_DRV);
  assign hit_conv = (paddr_in == pwe_pkg::ADDR_CONV);
  assign hit_sys = (paddr_in == pwe_pkg::ADDR_SYS);
  assign hit_stat = (paddr_in == pwe_pkg::ADDR_STAT);
  assign hit_key = (paddr_in == pwe_pkg::ADDR_KEY);
  assign hit_any = hit_drv | hit_conv | hit_sys | hit_stat | hit_key;
  assign wr_data = pwdata_in[pwe_pkg::REG_W-1:0];
  assign wr_bmask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

  // ****************************************************************
  // Enable registers
  // ****************************************************************
  logic [pwe_pkg::REG_W-1:0] drv_q;
  logic [pwe_pkg::REG_W-1:0] conv_q;
  logic [pwe_pkg::REG_W-1:0] sys_q;
  logic core_on;
  logic core_hold;
  logic unlocked_ff;
  logic nxt_unlocked;

  assign core_on = sys_q[pwe_pkg::SYS_CORE];
  assign core_hold = ~core_on;

  pwe_field_reg #(
    .W(pwe_pkg::REG_W),
    .RST_VAL(pwe_pkg::DRV_RST),
    .WR_MASK(pwe_pkg::DRV_MASK),
    .KEY_MASK(pwe_pkg::NO_KEY_MASK)
  ) u_drv_reg (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .hold_in(core_hold),
    .wr_in(wr_done & hit_drv),
    .wr_data_in(wr_data),
    .wr_bmask_in(wr_bmask),
    .unlocked_in(unlocked_ff),
    .q_out(drv_q)
  );

  pwe_field_reg #(
    .W(pwe_pkg::REG_W),
    .RST_VAL(pwe_pkg::CONV_RST),
    .WR_MASK(pwe_pkg::CONV_MASK),
    .KEY_MASK(pwe_pkg::NO_KEY_MASK)
  ) u_conv_reg (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .hold_in(core_hold),
    .wr_in(wr_done & hit_conv),
    .wr_data_in(wr_data),
    .wr_bmask_in(wr_bmask),
    .unlocked_in(unlocked_ff),
    .q_out(conv_q)
  );

  pwe_field_reg #(
    .W(pwe_pkg::REG_W),
    .RST_VAL(pwe_pkg::SYS_RST),
    .WR_MASK(pwe_pkg::SYS_MASK),
    .KEY_MASK(pwe_pkg::SYS_KEY_MASK)
  ) u_sys_reg (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .hold_in(sm_reset_in),
    .wr_in(wr_done & hit_sys),
    .wr_data_in(wr_data),
    .wr_bmask_in(wr_bmask),
    .unlocked_in(unlocked_ff),
    .q_out(sys_q)
  );

  // ****************************************************************
  // Security key and status
  // ****************************************************************
  logic key_viol_ff;
  logic nxt_key_viol;
  logic key_viol_set;
  logic key_viol_clr;
  logic [pwe_pkg::REG_W-1:0] key_diff;
  logic [pwe_pkg::REG_W-1:0] stat_word;

  assign key_diff = (wr_data ^ sys_q) & wr_bmask & pwe_pkg::SYS_KEY_MASK;
  assign key_viol_set = wr_done & hit_sys & ~unlocked_ff & (|key_diff);
  assign key_viol_clr = wr_done & hit_stat & pstrb_in[0] & wr_data[pwe_pkg::STAT_KEY_VIOL];

  always_comb begin
    nxt_unlocked = unlocked_ff;
    if (sm_reset_in) begin
      nxt_unlocked = 1'b0;
    end else if (wr_done & hit_key) begin
      nxt_unlocked = (pstrb_in[1:0] == 2'h3) && (wr_data == pwe_pkg::KEY_UNLOCK);
    end
    nxt_key_viol = key_viol_ff;
    if (key_viol_set) begin
      nxt_key_viol = 1'b1;
    end else if (key_viol_clr) begin
      nxt_key_viol = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      unlocked_ff <= 1'b0;
      key_viol_ff <= 1'b0;
    end else begin
      unlocked_ff <= nxt_unlocked;
      key_viol_ff <= nxt_key_viol;
    end
  end

  always_comb begin
    stat_word = '0;
    stat_word[pwe_pkg::STAT_UNLOCKED] = unlocked_ff;
    stat_word[pwe_pkg::STAT_CORE_ON] = core_on;
    stat_word[pwe_pkg::STAT_KEY_VIOL] = key_viol_ff;
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  // Answer registered in setup, so access phase sees pready at its first edge
  always_comb begin
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = prdata_ff;
    if (setup_phase) begin
      nxt_pready = 1'b1;
      nxt_pslverr = ~hit_any;
      nxt_prdata = '0;
      if (!pwrite_in) begin
        unique case (1'b1)
          hit_drv: nxt_prdata = {16'h0000, drv_q};
          hit_conv: nxt_prdata = {16'h0000, conv_q};
          hit_sys: nxt_prdata = {16'h0000, sys_q};
          hit_stat: nxt_prdata = {16'h0000, stat_word};
          default: nxt_prdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;

  // ****************************************************************
  // Enable outputs
  // ****************************************************************
  assign drv_out.beep_mixer_enable = drv_q[pwe_pkg::DRV_BEEP];
  assign drv_out.driver_two_right_enable = drv_q[pwe_pkg::DRV_O2R];
  assign drv_out.driver_two_left_enable = drv_q[pwe_pkg::DRV_O2L];
  assign drv_out.driver_one_right_enable = drv_q[pwe_pkg::DRV_O1R];
  assign drv_out.driver_one_left_enable = drv_q[pwe_pkg::DRV_O1L];

  assign conv_out.audio_core_clock_enable = conv_q[pwe_pkg::CONV_CLK];
  assign conv_out.input_highpass_enable = conv_q[pwe_pkg::CONV_HPF];
  assign conv_out.zero_cross_timeout_clock_enable = conv_q[pwe_pkg::CONV_TOCLK];
  assign conv_out.right_output_converter_enable = conv_q[pwe_pkg::CONV_DACR];
  assign conv_out.left_output_converter_enable = conv_q[pwe_pkg::CONV_DACL];
  assign conv_out.right_input_converter_enable = conv_q[pwe_pkg::CONV_ADCR];
  assign conv_out.left_input_converter_enable = conv_q[pwe_pkg::CONV_ADCL];

  assign sys_out.audio_core_master_enable = core_on;
  assign sys_out.clock_tick_enable = sys_q[pwe_pkg::SYS_TICK];
  assign sys_out.crystal_osc_enable = sys_q[pwe_pkg::SYS_OSC];
  assign sys_out.charger_control_enable = sys_q[pwe_pkg::SYS_CHG];
  assign sys_out.backup_rail_pin_enable = sys_q[pwe_pkg::SYS_BKP];
  assign sys_out.aux_converter_enable = sys_q[pwe_pkg::SYS_AUX];
  assign sys_out.comparator_enable = sys_q[3:0];

  // Audio core reset for the rest of the codec, low while master enable clear
  assign audio_core_rst_n_out = core_on;

endmodule : pwe_bank

// *** testbench/pwe_bank_chk.sv ***
// Concurrent checks on the power enable register bank ports.
// Assumes pwe_pkg is compiled first; bound onto every pwe_bank instance.
`timescale 1ns/100ps
module pwe_bank_chk (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [pwe_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic sm_reset_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire pwe_pkg::pwe_drv_s drv_out,
  input wire pwe_pkg::pwe_conv_s conv_out,
  input wire pwe_pkg::pwe_sys_s sys_out,
  input wire logic audio_core_rst_n_out
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  logic mapped;
  logic done;
  logic sys_wr;
  assign mapped = paddr_in inside {pwe_pkg::ADDR_DRV, pwe_pkg::ADDR_CONV, pwe_pkg::ADDR_SYS,
                                   pwe_pkg::ADDR_STAT, pwe_pkg::ADDR_KEY};
  assign done = psel_in && penable_in && pready_out;
  assign sys_wr = done && pwrite_in && (paddr_in == pwe_pkg::ADDR_SYS);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_sm_pulse;
    sm_reset_in ##1 1'b1;
  endsequence
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_answer;
    s_setup |=> pready_out;
  endproperty
  property p_pulse;
    pready_out |=> !pready_out;
  endproperty
  property p_unmapped;
    done && !mapped |-> pslverr_out;
  endproperty
  property p_mapped;
    done && mapped |-> !pslverr_out && (prdata_out[31:16] == 16'h0000);
  endproperty
  property p_core_link;
    audio_core_rst_n_out == sys_out.audio_core_master_enable;
  endproperty
  property p_hold;
    !sys_out.audio_core_master_enable && !$past(sys_out.audio_core_master_enable)
      |-> (drv_out == 5'h00) && (conv_out == 7'h20);
  endproperty
  property p_sm_defaults;
    sm_reset_in |=> (sys_out == 10'h1C0) && !audio_core_rst_n_out;
  endproperty
  property p_sm_audio;
    s_sm_pulse |=> (drv_out == 5'h00);
  endproperty
  property p_sys_quiet;
    !$past(sys_wr) && !$past(sm_reset_in) |-> $stable(sys_out);
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
  a_mapped: assert property (p_mapped) else $error("bad answer on mapped");
  a_core_link: assert property (p_core_link) else $error("core reset differs");
  a_hold: assert property (p_hold) else $error("audio regs not held");
  a_sm_defaults: assert property (p_sm_defaults) else $error("sys not restored");
  a_sm_audio: assert property (p_sm_audio) else $error("drivers not cleared");
  a_sys_quiet: assert property (p_sys_quiet) else $error("sys changed unasked");
endmodule : pwe_bank_chk

bind pwe_bank pwe_bank_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pstrb_in(pstrb_in), .sm_reset_in(sm_reset_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .drv_out(drv_out), .conv_out(conv_out),
  .sys_out(sys_out), .audio_core_rst_n_out(audio_core_rst_n_out));

// *** testbench/pwe_tb.sv ***
// Self-checking bench for the power enable register bank.
// Assumes pwe_pkg, the design files and the checker are compiled first.
`timescale 1ns/100ps
module testbench;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [3:0] pstrb_in = 4'h0;
  logic sm_reset_in = 1'b0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  pwe_pkg::pwe_drv_s drv_out;
  pwe_pkg::pwe_conv_s conv_out;
  pwe_pkg::pwe_sys_s sys_out;
  logic audio_core_rst_n_out;
  int fails = 0;
  int checks = 0;
  logic [15:0] rd_q;
  logic err_q;

  pwe_bank uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .sm_reset_in(sm_reset_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .drv_out(drv_out),
    .conv_out(conv_out), .sys_out(sys_out), .audio_core_rst_n_out(audio_core_rst_n_out));

  initial begin
    forever #2.5 clk_in = ~clk_in;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [15:0] data);
    int n;
    logic rdy;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= addr;
    pwdata_in <= {16'h0000, data};
    pstrb_in <= 4'h3;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    // Sample settled answer before the edge that completes the access
    do begin
      @(negedge clk_in);
      rdy = (pready_out === 1'b1);
      rd_q = prdata_out[15:0];
      err_q = pslverr_out;
      @(posedge clk_in);
      n++;
    end while (!rdy && n < 20);
    if (!rdy) begin
      $display("mismatch pready expected 1 seen timeout");
      fails++;
      end_of_test();
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask : apb

  task automatic rd(input logic [7:0] addr, input logic [15:0] exp, input string what);
    apb(1'b0, addr, 16'h0000);
    chk(what, exp, rd_q);
    chk({what, " err"}, 16'h0000, {15'h0000, err_q});
  endtask : rd

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(pwe_pkg::ADDR_DRV, 16'h0000, "drv reset");
    rd(pwe_pkg::ADDR_CONV, 16'h2000, "conv reset");
    rd(pwe_pkg::ADDR_SYS, 16'h0E00, "sys reset");
    chk("sys out", 16'h01C0, {6'h00, sys_out});
    chk("conv out", 16'h0020, {9'h000, conv_out});
    $display("test reset done");
  endtask : t_reset

  task automatic t_gate;
    apb(1'b1, pwe_pkg::ADDR_DRV, 16'h008F);
    rd(pwe_pkg::ADDR_DRV, 16'h0000, "drv held");
    apb(1'b1, pwe_pkg::ADDR_SYS, 16'h1000);
    rd(pwe_pkg::ADDR_SYS, 16'h1E00, "sys locked");
    apb(1'b1, pwe_pkg::ADDR_DRV, 16'hFFFF);
    rd(pwe_pkg::ADDR_DRV, 16'h008F, "drv on");
    chk("drv out", 16'h001F, {11'h000, drv_out});
    apb(1'b1, pwe_pkg::ADDR_CONV, 16'h010C);
    rd(pwe_pkg::ADDR_CONV, 16'h010C, "conv on");
    chk("conv out", 16'h0013, {9'h000, conv_out});
    $display("test gate done");
  endtask : t_gate

  task automatic t_key;
    apb(1'b1, pwe_pkg::ADDR_KEY, pwe_pkg::KEY_UNLOCK);
    apb(1'b1, pwe_pkg::ADDR_SYS, 16'h118F);
    rd(pwe_pkg::ADDR_SYS, 16'h118F, "sys unlocked");
    chk("sys out", 16'h023F, {6'h00, sys_out});
    $display("test key done");
  endtask : t_key

  task automatic t_sm;
    sm_reset_in <= 1'b1;
    @(posedge clk_in);
    sm_reset_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rd(pwe_pkg::ADDR_SYS, 16'h0E00, "sys sm");
    rd(pwe_pkg::ADDR_DRV, 16'h0000, "drv sm");
    rd(pwe_pkg::ADDR_CONV, 16'h2000, "conv sm");
    apb(1'b1, pwe_pkg::ADDR_SYS, 16'h1000);
    rd(pwe_pkg::ADDR_SYS, 16'h1E00, "sys relocked");
    $display("test state reset done");
  endtask : t_sm

  task automatic t_unmapped;
    apb(1'b0, 8'h34, 16'h0000);
    chk("unmapped err", 16'h0001, {15'h0000, err_q});
    chk("unmapped data", 16'h0000, rd_q);
    $display("test unmapped done");
  endtask : t_unmapped

  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_gate();
    t_key();
    t_sm();
    t_unmapped();
    end_of_test();
  end
endmodule : testbench
